//--- hw/cmbt_ctrl.sv
// CAN message buffer configuration and transmit request controller
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns

// Contract
// (RQ1) Config registers written only when change-enable and init are both set.
// (RQ2) Received data longer than element size is truncated to configured bytes.
// (RQ3) Size codes 0..7 decode to 8,12,16,20,24,32,48,64 bytes.
// (RQ4) Software uses sizes above eight bytes only for FD operation.
// (RQ5) Software keeps shared plus dedicated buffer count at most 32.
// (RQ6) Dedicated buffers come first, shared buffers follow them.
// (RQ7) Mode bit 30: zero FIFO, one queue.
// (RQ8) Shared count bits 29:24: zero none, above 32 means 32.
// (RQ9) Dedicated count bits 21:16: zero none, above 32 means 32.
// (RQ10) Section start bits 15:2 hold a word address.
// (RQ11) Shared status derives from pending vector, may lag a scan.
// (RQ12) Put and get indices are absolute buffer numbers.
// (RQ13) Status full flag bit 21, put index bits 20:16.
// (RQ14) Get index bits 12:8, zero in queue mode.
// (RQ15) Free level bits 5:0, zero in queue mode.
// (RQ16) Bytes beyond Tx element size are sent as 0xcc.
// (RQ17) Pending bit set by add for configured buffers, cleared on finish or cancel.
// (RQ18) After pending set, a scan picks the lowest identifier.
// (RQ19) Bits set during a scan are excluded; their cancel acts immediately.
// (RQ20) Cancel of frame in progress waits for its end; cancel bit clears after.
// (RQ21) Cancel finished set on success, not started, lost arbitration or error.
// (RQ22) With retransmission disabled, failed sends are cancelled and flagged.
// (RQ23) Add for an already pending buffer is ignored.
// (RQ24) Occurred bit set on successful finish, cleared by new add.
// (RQ25) Unassigned bits read zero and ignore writes.
module cmbt_ctrl
   import cmbt_pkg::*;
#(
   parameter int NBUF = 32
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Identifier of each buffer, read from message RAM
   input wire logic [NBUF*29-1:0] buf_id_i,
   // Engine events for the buffer now on the bus
   input wire logic tx_done_ok_i,
   input wire logic tx_done_fail_i,
   // Element lengths
   input wire logic [6:0] rx_frame_bytes_i,
   input wire logic [1:0] rx_target_i,
   input wire logic [6:0] tx_dlc_bytes_i,
   input wire logic [5:0] tx_byte_index_i,
   input wire logic [7:0] tx_ram_byte_i,
   output logic [6:0] rx_store_bytes_o,
   output logic [7:0] tx_byte_o,
   output logic tx_start_o,
   output logic [4:0] tx_buf_o,
   output logic [15:0] tx_section_addr_o,
   output logic fd_sizes_o
);

   logic [31:0] rx_elem_r, tx_cfg_r, tx_elem_r, ctrl_r;
   logic [31:0] pend_r, cancel_r, occ_r, cfin_r, scan_mask_r;
   logic [31:0] add_set, cancel_set, cfg_mask, done_clr;
   logic [4:0] cur_r, best_r, scan_idx_r;
   logic [28:0] best_id_r;
   logic best_ok_r;
   logic ack_r;
   logic wr_acc, rd_acc, cfg_open;
   cmbt_state_e state_r;
   logic [5:0] dedicated_tx_buffer_count, tx_shared_buffer_count;
   logic [31:0] wdata;
   logic [4:0] put_idx, get_idx;
   logic [5:0] free_lvl;
   logic full;
   logic [31:0] status_w;
   logic [31:0] idle_cancel;
   logic scan_take;

   // Size code to bytes
   function automatic logic [6:0] size_bytes(input logic [2:0] code);
      unique case (code) // RQ3
         3'h0: size_bytes = 7'h08;
         3'h1: size_bytes = 7'h0c;
         3'h2: size_bytes = 7'h10;
         3'h3: size_bytes = 7'h14;
         3'h4: size_bytes = 7'h18;
         3'h5: size_bytes = 7'h20;
         3'h6: size_bytes = 7'h30;
         default: size_bytes = 7'h40;
      endcase
   endfunction : size_bytes

   // Count field with clamp at 32
   function automatic logic [5:0] clamp32(input logic [5:0] v);
      clamp32 = (v > MAX_BUFS) ? MAX_BUFS : v;
   endfunction : clamp32

   // Bus handshake: one wait cycle, answer on second
   assign wr_acc = avs_write_i & ack_r;
   // Read data loads in the wait cycle so it stands when waitrequest drops
   assign rd_acc = avs_read_i & ~ack_r;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
   end

   // Byte lane merge
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         wdata[i*8 +: 8] = avs_byteenable_i[i] ? avs_writedata_i[i*8 +: 8] : 8'h00;
   end

   assign cfg_open = ctrl_r[CTRL_CCE_BIT] & ctrl_r[CTRL_INIT_BIT];
   assign dedicated_tx_buffer_count = clamp32(tx_cfg_r[DEDICATED_TX_BUFFER_COUNT_LSB +: 6]); // RQ9
   assign tx_shared_buffer_count = clamp32(tx_cfg_r[TX_SHARED_BUFFER_COUNT_LSB +: 6]); // RQ8

   // Configured buffer mask
   always_comb
   begin
      for (int i = 0; i < 32; i++)
         cfg_mask[i] = (7'(i) < (7'(dedicated_tx_buffer_count) + 7'(tx_shared_buffer_count)));
   end

   // Control register (change enable, init, retransmit disable)
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_r <= CTRL_RESET;
      else if (wr_acc && avs_address_i == OFS_CTRL)
         ctrl_r <= wdata & CTRL_MASK; // RQ25
   end

   // Configuration registers, gated by change enable and init
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_elem_r <= CFG_RESET;
         tx_cfg_r <= CFG_RESET;
         tx_elem_r <= CFG_RESET;
      end
      else if (wr_acc && cfg_open) // RQ1
      begin
         if (avs_address_i == OFS_RX_ELEM_SIZE)
            rx_elem_r <= wdata & RX_ELEM_MASK; // RQ25
         if (avs_address_i == OFS_TX_BUF_CFG)
            tx_cfg_r <= wdata & TX_CFG_MASK; // RQ7 RQ10
         if (avs_address_i == OFS_TX_ELEM_SIZE)
            tx_elem_r <= wdata & TX_ELEM_MASK;
      end
   end

   // Add and cancel requests only for configured buffers
   assign add_set = (wr_acc && avs_address_i == OFS_TX_ADD_REQ) ? (wdata & cfg_mask & ~pend_r) : '0; // RQ17 RQ23
   assign cancel_set = (wr_acc && avs_address_i == OFS_TX_CANCEL_REQ) ? (wdata & cfg_mask) : '0;

   // Finish of the buffer on the bus
   assign done_clr = (state_r == CMBT_SEND && (tx_done_ok_i || tx_done_fail_i)
                      && (tx_done_ok_i || cancel_r[cur_r] || ctrl_r[CTRL_DAR_BIT]))
                     ? (32'h1 << cur_r) : '0;

   // Cancels of buffers not now on the bus act at once
   always_comb
   begin
      idle_cancel = cancel_r & pend_r; // RQ19
      if (state_r == CMBT_SEND)
         idle_cancel[cur_r] = 1'b0; // RQ20
   end

   // Pending, cancel, occurred and cancel-finished vectors
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pend_r <= '0;
         cancel_r <= '0;
         occ_r <= '0;
         cfin_r <= '0;
      end
      else
      begin
         // Clear before set so a new add wins
         pend_r <= (pend_r & ~idle_cancel & ~done_clr) | add_set; // RQ17 RQ19
         cancel_r <= (cancel_r & pend_r & ~idle_cancel & ~done_clr) | (cancel_set & ~cancel_r); // RQ20
         occ_r <= (occ_r | (tx_done_ok_i ? done_clr : '0)) & ~add_set; // RQ24
         cfin_r <= (cfin_r | idle_cancel | (cancel_set & ~pend_r)
                   | (done_clr & (cancel_r | (tx_done_fail_i ? '1 : '0)))) & ~add_set; // RQ21 RQ22
      end
   end

   // Candidate of the scan: pending at scan start, still pending, lowest so far
   assign scan_take = scan_mask_r[scan_idx_r] && pend_r[scan_idx_r] &&
                      (!best_ok_r || buf_id_i[scan_idx_r*29 +: 29] < best_id_r); // RQ18 RQ19

   // Scan and send sequencer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= CMBT_IDLE;
         scan_mask_r <= '0;
         scan_idx_r <= '0;
         best_r <= '0;
         best_id_r <= '0;
         best_ok_r <= 1'b0;
         cur_r <= '0;
      end
      else
      begin
         unique case (state_r)
            CMBT_IDLE:
            begin
               if (|pend_r) // RQ18
               begin
                  scan_mask_r <= pend_r; // RQ19
                  scan_idx_r <= '0;
                  best_ok_r <= 1'b0;
                  state_r <= CMBT_SCAN;
               end
            end
            CMBT_SCAN:
            begin
               if (scan_take)
               begin
                  best_r <= scan_idx_r; // RQ18
                  best_id_r <= buf_id_i[scan_idx_r*29 +: 29];
                  best_ok_r <= 1'b1;
               end
               scan_idx_r <= scan_idx_r + 5'h01;
               if (scan_idx_r == 5'h1f)
               begin
                  // The last buffer may itself be the winner
                  cur_r <= scan_take ? scan_idx_r : best_r;
                  state_r <= CMBT_IDLE;
                  if (scan_take || (best_ok_r && pend_r[best_r]))
                     state_r <= CMBT_SEND;
               end
            end
            CMBT_SEND:
            begin
               if (tx_done_ok_i || tx_done_fail_i)
                  state_r <= CMBT_IDLE;
            end
            default: state_r <= CMBT_IDLE;
         endcase
      end
   end

   assign tx_start_o = (state_r == CMBT_SEND);
   assign tx_buf_o = cur_r;
   assign tx_section_addr_o = {tx_cfg_r[TX_SECTION_START_WORD_LSB +: 14], 2'b00}; // RQ10
   assign fd_sizes_o = (|rx_elem_r) | (|tx_elem_r); // RQ4

   // Shared area status; dedicated buffers come first
   always_comb
   begin
      logic [5:0] k;
      logic stop;
      logic [31:0] shared;
      put_idx = '0;
      get_idx = '0;
      free_lvl = '0;
      full = 1'b0;
      k = '0;
      stop = 1'b0;
      shared = cfg_mask & ~((32'h1 << dedicated_tx_buffer_count) - 32'h1);
      // Put index: first free shared buffer, absolute number
      for (int i = 31; i >= 0; i--)
         if (6'(i) >= dedicated_tx_buffer_count && 7'(i) < 7'(dedicated_tx_buffer_count) + 7'(tx_shared_buffer_count) && !pend_r[i])
            put_idx = 5'(i); // RQ6 RQ11 RQ12
      full = (shared != '0) && ((pend_r & shared) == shared); // RQ13
      if (!tx_cfg_r[TX_SHARED_MODE_SELECT_BIT] && tx_shared_buffer_count != 6'h00) // RQ7 RQ14 RQ15
      begin
         // Get index: oldest pending after the put slot
         for (int j = 1; j <= 32; j++)
         begin
            k = 6'((put_idx - dedicated_tx_buffer_count + 6'(j)) % tx_shared_buffer_count);
            if (!stop && pend_r[5'(k + dedicated_tx_buffer_count)])
            begin
               get_idx = 5'(k + dedicated_tx_buffer_count);
               stop = 1'b1;
            end
         end
         if (!stop)
            get_idx = put_idx;
         free_lvl = full ? 6'h00 : 6'(tx_shared_buffer_count - 6'($countones(pend_r & cfg_mask) - $countones(pend_r & ((32'h1 << dedicated_tx_buffer_count) - 32'h1))));
      end
   end

   assign status_w = {10'h000, full, put_idx, 3'h0, get_idx, 2'h0, free_lvl}; // RQ13 RQ14 RQ15

   // Read data register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         avs_readdata_o <= '0;
      else if (rd_acc)
      begin
         unique case (avs_address_i)
            OFS_RX_ELEM_SIZE: avs_readdata_o <= rx_elem_r;
            OFS_TX_BUF_CFG: avs_readdata_o <= tx_cfg_r;
            OFS_TX_FQ_STATUS: avs_readdata_o <= status_w;
            OFS_TX_ELEM_SIZE: avs_readdata_o <= tx_elem_r;
            OFS_TX_REQ_PEND: avs_readdata_o <= pend_r;
            OFS_TX_CANCEL_REQ: avs_readdata_o <= cancel_r;
            OFS_TX_OCCURRED: avs_readdata_o <= occ_r;
            OFS_TX_CANCEL_FIN: avs_readdata_o <= cfin_r;
            OFS_CTRL: avs_readdata_o <= ctrl_r;
            default: avs_readdata_o <= '0; // RQ25
         endcase
      end
   end
   assign avs_response_o = 2'b00;

   // Rx store length and Tx padding
   always_comb
   begin
      logic [6:0] lim;
      lim = '0;
      unique case (rx_target_i)
         2'h0: lim = size_bytes(rx_elem_r[RX_FIFO_ZERO_DATA_SIZE_LSB +: 3]);
         2'h1: lim = size_bytes(rx_elem_r[RX_FIFO_ONE_DATA_SIZE_LSB +: 3]);
         default: lim = size_bytes(rx_elem_r[RX_BUFFER_DATA_SIZE_LSB +: 3]);
      endcase
      rx_store_bytes_o = (rx_frame_bytes_i > lim) ? lim : rx_frame_bytes_i; // RQ2
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tx_byte_o <= '0;
      else
         tx_byte_o <= (7'(tx_byte_index_i) >= size_bytes(tx_elem_r[TX_BUFFER_DATA_SIZE_LSB +: 3]) &&
                       7'(tx_byte_index_i) < tx_dlc_bytes_i) ? PAD_BYTE : tx_ram_byte_i; // RQ16
   end

   AST_CFG_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_acc && !cfg_open && avs_address_i == OFS_TX_BUF_CFG) |=> $stable(tx_cfg_r)) // RQ1
      else $error("Config written while locked");
   AST_ADD_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_acc && avs_address_i == OFS_TX_ADD_REQ && (wdata & pend_r) != '0)
      |=> ((($past(occ_r) & ~occ_r) | ($past(cfin_r) & ~cfin_r))
           & $past(wdata & pend_r)) == '0) // RQ23
      else $error("Add accepted for pending buffer");
   AST_CANCEL_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
      (cancel_r & ~pend_r & ~$past(cancel_set)) == '0) // RQ20
      else $error("Cancel request outlived its pending bit");
   AST_UNCFG: assert property (@(posedge clk_i) disable iff (rst_i) ((pend_r & ~cfg_mask & ~$past(pend_r)) == '0)) // RQ17
      else $error("Pending set on unconfigured buffer");
   AST_Q_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_cfg_r[TX_SHARED_MODE_SELECT_BIT] |-> (get_idx == '0 && free_lvl == '0)) // RQ14
      else $error("Get or free nonzero in queue mode");
   AST_OCC: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_done_ok_i && state_r == CMBT_SEND) |=> (occ_r[$past(cur_r)] && !pend_r[$past(cur_r)])) // RQ24
      else $error("Occurred not set");
   AST_SEND_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == CMBT_SEND && !tx_done_ok_i && !tx_done_fail_i) |=> pend_r[cur_r]) // RQ20
      else $error("Pending cleared mid frame");
   AST_DAR: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_r[CTRL_DAR_BIT] && tx_done_fail_i && state_r == CMBT_SEND) |=> cfin_r[$past(cur_r)]) // RQ22
      else $error("Failed send not flagged");
   AST_SCAN_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(state_r == CMBT_SCAN) |-> (state_r == CMBT_SCAN) [*8]) // RQ18
      else $error("Scan ended early");
   CV_SEND: cover property (@(posedge clk_i) state_r == CMBT_SEND);
   CV_CANCEL: cover property (@(posedge clk_i) |cancel_set);
   CV_FULL: cover property (@(posedge clk_i) full && tx_shared_buffer_count != 6'h00);
   CV_CANCEL_LIVE: cover property (@(posedge clk_i) state_r == CMBT_SEND && cancel_r[cur_r]);
endmodule : cmbt_ctrl

//--- hw/cmbt_pkg.sv
// Constants for the CAN message buffer and transmit request controller
package cmbt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_RX_ELEM_SIZE = 8'hbc;
   localparam logic [7:0] OFS_TX_BUF_CFG = 8'hc0;
   localparam logic [7:0] OFS_TX_FQ_STATUS = 8'hc4;
   localparam logic [7:0] OFS_TX_ELEM_SIZE = 8'hc8;
   localparam logic [7:0] OFS_TX_REQ_PEND = 8'hcc;
   localparam logic [7:0] OFS_TX_ADD_REQ = 8'hd0;
   localparam logic [7:0] OFS_TX_CANCEL_REQ = 8'hd4;
   localparam logic [7:0] OFS_TX_OCCURRED = 8'hd8;
   localparam logic [7:0] OFS_TX_CANCEL_FIN = 8'hdc;
   localparam logic [7:0] OFS_CTRL = 8'he8;
   // Field positions
   localparam int RX_BUFFER_DATA_SIZE_LSB = 8;
   localparam int RX_FIFO_ONE_DATA_SIZE_LSB = 4;
   localparam int RX_FIFO_ZERO_DATA_SIZE_LSB = 0;
   localparam int TX_BUFFER_DATA_SIZE_LSB = 0;
   localparam int TX_SHARED_MODE_SELECT_BIT = 30;
   localparam int TX_SHARED_BUFFER_COUNT_LSB = 24;
   localparam int DEDICATED_TX_BUFFER_COUNT_LSB = 16;
   localparam int TX_SECTION_START_WORD_LSB = 2;
   localparam int TX_SHARED_FULL_FLAG_BIT = 21;
   localparam int TX_SHARED_PUT_INDEX_LSB = 16;
   localparam int TX_FIFO_GET_INDEX_LSB = 8;
   localparam int TX_FIFO_FREE_LEVEL_LSB = 0;
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_CCE_BIT = 1;
   localparam int CTRL_DAR_BIT = 6;
   // Writable masks and reset values
   localparam logic [31:0] RX_ELEM_MASK = 32'h0000_0777;
   localparam logic [31:0] TX_CFG_MASK = 32'h7f3f_fffc;
   localparam logic [31:0] TX_ELEM_MASK = 32'h0000_0007;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0043;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [5:0] MAX_BUFS = 6'h20;
   localparam logic [7:0] PAD_BYTE = 8'hcc;
   // Transmit engine states
   typedef enum logic [2:0]
   {
      CMBT_IDLE = 3'b001,
      CMBT_SCAN = 3'b010,
      CMBT_SEND = 3'b100
   } cmbt_state_e;
endpackage : cmbt_pkg

//--- bench/cmbt_bus_model.sv
// Model of the CAN bus end of a frame for the transmit controller
`timescale 1ns/1ns
module cmbt_bus_model
#(
   parameter int FRAME_CYCLES = 20
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_start_i,
   input wire logic [4:0] tx_buf_i,
   input wire logic fail_mode_i,
   output logic done_ok_o,
   output logic done_fail_o,
   output logic [4:0] last_buf_o,
   output int n_sent_o
);
   logic busy_r;
   int cnt_r;
   // One end pulse per started frame, then wait for start to drop
   always_ff @(posedge clk_i)
   begin
      done_ok_o <= 1'b0;
      done_fail_o <= 1'b0;
      if (rst_i)
      begin
         busy_r <= 1'b0;
         cnt_r <= 0;
         n_sent_o <= 0;
         last_buf_o <= 5'h00;
      end
      else if (!busy_r && tx_start_i)
      begin
         busy_r <= 1'b1;
         cnt_r <= FRAME_CYCLES;
         last_buf_o <= tx_buf_i;
      end
      else if (cnt_r > 1)
         cnt_r <= cnt_r - 1;
      else if (cnt_r == 1)
      begin
         done_ok_o <= !fail_mode_i;
         done_fail_o <= fail_mode_i;
         n_sent_o <= n_sent_o + 1;
         cnt_r <= 0;
      end
      else if (busy_r && !tx_start_i)
         busy_r <= 1'b0;
   end
endmodule : cmbt_bus_model

//--- bench/testbench.sv
// Register level tests of the transmit request controller
`timescale 1ns/1ns
module testbench;
   import cmbt_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] a_r = 8'h00;
   logic rd_r = 1'b0;
   logic wr_r = 1'b0;
   logic [31:0] wd_r = 32'h0;
   logic [31:0] rdata, q;
   logic wait_o, ok, fail, fmode = 1'b0, tx_start_o, fd_o;
   logic [1:0] resp, rx_target_i = 2'h0;
   logic [28:0] ids [32];
   logic [32*29-1:0] buf_id_i;
   logic [6:0] rx_frame_bytes_i = 7'h40, rx_store_bytes_o;
   logic [5:0] tx_byte_index_i = 6'h00;
   logic [7:0] tx_byte_o;
   logic [4:0] tx_buf_o, last_buf;
   logic [15:0] sect_o;
   int failures = 0, n_compared = 0, cycles = 0, n_sent;
   int sz [8] = '{8, 12, 16, 20, 24, 32, 48, 64};
   always #50 clk_i = ~clk_i;
   // Identifier table seen by the scan
   always_comb
      for (int i = 0; i < 32; i++)
         buf_id_i[i*29+:29] = ids[i];
   cmbt_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(a_r), .avs_read_i(rd_r), .avs_write_i(wr_r),
      .avs_writedata_i(wd_r), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .avs_response_o(resp), .buf_id_i(buf_id_i), .tx_done_ok_i(ok), .tx_done_fail_i(fail),
      .rx_frame_bytes_i(rx_frame_bytes_i), .rx_target_i(rx_target_i), .tx_dlc_bytes_i(7'h40),
      .tx_byte_index_i(tx_byte_index_i), .tx_ram_byte_i(8'h5a), .rx_store_bytes_o(rx_store_bytes_o),
      .tx_byte_o(tx_byte_o), .tx_start_o(tx_start_o), .tx_buf_o(tx_buf_o), .tx_section_addr_o(sect_o),
      .fd_sizes_o(fd_o));
   cmbt_bus_model bus_far (.clk_i(clk_i), .rst_i(rst_i), .tx_start_i(tx_start_o), .tx_buf_i(tx_buf_o),
      .fail_mode_i(fmode), .done_ok_o(ok), .done_fail_o(fail), .last_buf_o(last_buf), .n_sent_o(n_sent));
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One Avalon access held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      a_r <= a;
      wd_r <= d;
      wr_r <= w;
      rd_r <= !w;
      @(posedge clk_i);
      while (wait_o !== 1'b0)
         @(posedge clk_i);
      q = rdata;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      // Idle cycle so the next request starts from a released bus
      @(posedge clk_i);
   endtask : bus
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk(what, exp, q & m);
   endtask : rd
   task automatic wsent(input int n);
      while (n_sent < n)
         @(posedge clk_i);
   endtask : wsent
   task automatic tick();
      @(posedge clk_i);
      @(posedge clk_i);
   endtask : tick
   logic [7:0] offs [5] = '{OFS_RX_ELEM_SIZE, OFS_TX_BUF_CFG, OFS_TX_FQ_STATUS, OFS_TX_ELEM_SIZE, OFS_TX_REQ_PEND};
   logic [31:0] masks [5] = '{RX_ELEM_MASK, TX_CFG_MASK, 32'h0, TX_ELEM_MASK, 32'h0};
   // Main sequence
   initial
   begin
      for (int i = 0; i < 32; i++)
         ids[i] = 29'h100 + 29'(i);
      ids[2] = 29'h5;
      ids[3] = 29'h1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd("ctrl reset", OFS_CTRL, CTRL_RESET, 32'hffffffff);
      for (int i = 0; i < 5; i++)
      begin
         rd("reset value", offs[i], CFG_RESET, 32'hffffffff);
         bus(1'b1, offs[i], 32'hffffffff);
         rd("locked write", offs[i], 32'h0, 32'hffffffff);
      end
      chk("fd classic", 32'h0, {31'h0, fd_o});
      bus(1'b1, OFS_CTRL, 32'h3);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b1, offs[i], 32'hffffffff);
         rd("open write", offs[i], masks[i], 32'hffffffff);
      end
      chk("section address", 32'hfffc, {16'h0, sect_o});
      rd("unmapped", 8'hf0, 32'h0, 32'hffffffff);
      $display("test registers done");
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b1, OFS_RX_ELEM_SIZE, 32'(c << 8 | (7 - c) << 4 | c));
         bus(1'b1, OFS_TX_ELEM_SIZE, 32'(c));
         for (int t = 0; t < 3; t++)
         begin
            rx_target_i <= 2'(t);
            tick();
            chk("rx store", 32'(t == 1 ? sz[7 - c] : sz[c]), {25'h0, rx_store_bytes_o});
         end
         tx_byte_index_i <= 6'(sz[c] - 1);
         tick();
         chk("tx data byte", 32'h5a, {24'h0, tx_byte_o});
         if (c < 7)
         begin
            tx_byte_index_i <= 6'(sz[c]);
            tick();
            chk("tx pad byte", 32'(PAD_BYTE), {24'h0, tx_byte_o});
         end
      end
      rx_frame_bytes_i <= 7'h05;
      tick();
      chk("rx short", 32'h5, {25'h0, rx_store_bytes_o});
      chk("fd sizes", 32'h1, {31'h0, fd_o});
      $display("test sizes done");
      bus(1'b1, OFS_TX_BUF_CFG, 32'h3f00_0000);
      rd("oversize fifo", OFS_TX_FQ_STATUS, 32'h20, 32'h3f);
      bus(1'b1, OFS_TX_BUF_CFG, 32'h4404_0100);
      rd("queue status", OFS_TX_FQ_STATUS, 32'h0, 32'h1f3f);
      bus(1'b1, OFS_TX_BUF_CFG, 32'h0404_0100);
      rd("fifo status", OFS_TX_FQ_STATUS, 32'h0004_0004, 32'h003f_003f);
      // Classic Tx element size and at most 32 buffers in total
      bus(1'b1, OFS_TX_ELEM_SIZE, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h0);
      $display("test status done");
      bus(1'b1, OFS_TX_ADD_REQ, 32'h405);
      rd("pending", OFS_TX_REQ_PEND, 32'h5, 32'hffffffff);
      wsent(1);
      chk("first sent", 32'h2, {27'h0, last_buf});
      wsent(2);
      chk("second sent", 32'h0, {27'h0, last_buf});
      rd("pending done", OFS_TX_REQ_PEND, 32'h0, 32'hffffffff);
      rd("occurred", OFS_TX_OCCURRED, 32'h5, 32'hffffffff);
      bus(1'b1, OFS_TX_ADD_REQ, 32'h2);
      bus(1'b1, OFS_TX_ADD_REQ, 32'h8);
      wsent(3);
      chk("scan exclusion", 32'h1, {27'h0, last_buf});
      while (tx_start_o !== 1'b0)
         @(posedge clk_i);
      while (tx_start_o !== 1'b1)
         @(posedge clk_i);
      bus(1'b1, OFS_TX_ADD_REQ, 32'h8);
      bus(1'b1, OFS_TX_CANCEL_REQ, 32'h8);
      rd("cancel in flight", OFS_TX_REQ_PEND, 32'h8, 32'hffffffff);
      wsent(4);
      rd("pending after end", OFS_TX_REQ_PEND, 32'h0, 32'hffffffff);
      rd("cancel cleared", OFS_TX_CANCEL_REQ, 32'h0, 32'hffffffff);
      rd("finished ok", OFS_TX_CANCEL_FIN, 32'h8, 32'hffffffff);
      bus(1'b1, OFS_TX_ADD_REQ, 32'h10);
      bus(1'b1, OFS_TX_CANCEL_REQ, 32'h10);
      rd("cancel early", OFS_TX_REQ_PEND, 32'h0, 32'hffffffff);
      rd("finished early", OFS_TX_CANCEL_FIN, 32'h18, 32'hffffffff);
      $display("test requests done");
      bus(1'b1, OFS_CTRL, 32'h40);
      fmode <= 1'b1;
      bus(1'b1, OFS_TX_ADD_REQ, 32'h1);
      wsent(5);
      rd("auto cancel", OFS_TX_REQ_PEND, 32'h0, 32'hffffffff);
      rd("finished fail", OFS_TX_CANCEL_FIN, 32'h19, 32'hffffffff);
      rd("occurred after fail", OFS_TX_OCCURRED, 32'he, 32'hffffffff);
      $display("test retransmit done");
      give_verdict();
   end
endmodule : testbench
